// ===== rtl/acrb_pkg.sv
// Shared constants and carrier types of the analog control register bank.
// Assumes a 40 MHz bus clock and 16-bit registers on a 32-bit AXI4-Lite bus.
package acrb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map: printed index, storage slot, byte address = 4 * index
  typedef logic [15:0] acrb_word_t;
  localparam int         ACRB_NREG        = 7;
  localparam int         ACRB_IDX_PCFG    = 32'h00;
  localparam int         ACRB_IDX_PCTL    = 32'h02;
  localparam int         ACRB_IDX_LCFG    = 32'h04;
  localparam int         ACRB_IDX_LPIN    = 32'h06;
  localparam int         ACRB_IDX_RCFG    = 32'h08;
  localparam int         ACRB_IDX_RRTE    = 32'h0A;
  localparam int         ACRB_IDX_BIAS    = 32'h0C;
  localparam int         ACRB_S_PCFG      = ACRB_IDX_PCFG / 2;
  localparam int         ACRB_S_PCTL      = ACRB_IDX_PCTL / 2;
  localparam int         ACRB_S_LCFG      = ACRB_IDX_LCFG / 2;
  localparam int         ACRB_S_LPIN      = ACRB_IDX_LPIN / 2;
  localparam int         ACRB_S_RCFG      = ACRB_IDX_RCFG / 2;
  localparam int         ACRB_S_RRTE      = ACRB_IDX_RRTE / 2;
  localparam int         ACRB_S_BIAS      = ACRB_IDX_BIAS / 2;
  localparam int         ACRB_ADDR_W      = 8;

  // Reset values, writable bits and reset-class masks, by slot
  localparam acrb_word_t ACRB_RST [ACRB_NREG] = '{16'h0100, 16'h0002,
    16'h0000, 16'hFFFF, 16'h0000, 16'h0010, 16'h1000};
  localparam acrb_word_t ACRB_WMASK [ACRB_NREG] = '{16'h0FFF, 16'hFFFF,
    16'h0011, 16'hFFFF, 16'h33F7, 16'hFFFF, 16'hFFFF};
  localparam acrb_word_t ACRB_PUC_M [ACRB_NREG] = '{16'hFFFF, 16'hFFFF,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
  localparam acrb_word_t ACRB_POR_M [ACRB_NREG] = '{16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam acrb_word_t ACRB_BOR_M [ACRB_NREG] = '{16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int         ACRB_F_DIV       = 0;
  localparam int         ACRB_F_THR       = 3;
  localparam int         ACRB_F_HYST      = 6;
  localparam int         ACRB_F_PD        = 8;
  localparam int         ACRB_F_TEST      = 9;
  localparam int         ACRB_F_FORCE     = 10;
  localparam int         ACRB_F_SRC       = 11;
  localparam int         ACRB_F_OK        = 12;
  localparam int         ACRB_F_QUIET     = 0;
  localparam int         ACRB_F_CLSRC     = 1;
  localparam int         ACRB_F_FCLAMP    = 2;
  localparam int         ACRB_F_EXTCAP    = 3;
  localparam int         ACRB_F_RATE      = 4;
  localparam int         ACRB_F_VLVL      = 6;
  localparam int         ACRB_F_COM       = 0;
  localparam int         ACRB_F_SEG       = 4;
  localparam int         ACRB_F_TRIM      = 0;
  localparam int         ACRB_F_SHUT      = 4;
  localparam int         ACRB_F_BYP       = 5;
  localparam int         ACRB_F_SCAP      = 6;
  localparam int         ACRB_F_LCAP      = 7;
  localparam int         ACRB_F_SW        = 12;
  localparam int         ACRB_F_PAD       = 0;
  localparam int         ACRB_F_ADC       = 4;
  localparam logic [1:0] ACRB_SW_CLOSED   = 2'h3;
  localparam logic [1:0] ACRB_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ACRB_RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: figures in their own units, cycle counts derived from them
  localparam int         ACRB_CLK_HZ      = 40_000_000;
  localparam int         ACRB_SRC_HZ      = 4_000_000;
  localparam int         ACRB_HALF_CYC    = ACRB_CLK_HZ / (2 * ACRB_SRC_HZ);
  localparam int         ACRB_RATE_SLOW_CHZ = 15625;
  localparam int         ACRB_RATE_MID_CHZ  = 31250;
  localparam int         ACRB_RATE_FAST_CHZ = 62500;
  localparam int         ACRB_SLOW_CYC    =
    (ACRB_CLK_HZ / ACRB_RATE_SLOW_CHZ) * 100;
  localparam int         ACRB_MID_CYC     =
    (ACRB_CLK_HZ / ACRB_RATE_MID_CHZ) * 100;
  localparam int         ACRB_FAST_CYC    =
    (ACRB_CLK_HZ / ACRB_RATE_FAST_CHZ) * 100;
  localparam int         ACRB_PULSE_US    = 50;
  localparam int         ACRB_PULSE_CYC   =
    ACRB_PULSE_US * (ACRB_CLK_HZ / 1_000_000);

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types towards the analog blocks
  typedef struct packed {
    logic       power_down;
    logic       clock;
    logic       clamp;
    logic [2:0] threshold;
    logic [1:0] hysteresis;
    logic       ext_cap;
    logic [1:0] valid_level;
    logic       refresh_pulse;
  } acrb_pump_s;

  typedef struct packed {
    logic [3:0]  common;
    logic [11:0] segment;
  } acrb_lcd_s;

  typedef struct packed {
    logic [2:0] trim;
    logic       open;
    logic       short_vdd;
    logic       small_cap;
    logic       large_cap;
    logic       switch_closed;
    logic [3:0] pad_route;
    logic       a0_from_p3_3;
  } acrb_ldo_s;

endpackage : acrb_pkg

// ===== rtl/acrb_top.sv
// Analog control register bank with AXI4-Lite slave and pump sequencing.
// Assumes all inputs synchronous to aclk; resets are synchronous, active low.
`timescale 1ns/100ps

// Summary of operation
// - Normal reset restores all ordinary-class bits
// - Power-on class bits survive watchdog reset
// - Brownout class bits restored only by brownout
// - Divide field picks 4 MHz over power-of-two
// - Threshold field selects pump valid voltage
// - Power-down bit stops pump, resets to one
// - Test mode: clock follows force-clock bit
// - Source bit picks internal or external clock
// - Read-only pump valid flag, zero after reset
// - Quiet bit stops all pump clocking
// - Clamp follows power-down or force-clamp bit
// - Refresh rate field sets refresh frequency
// - Each refresh tick is one 50 us pulse
// - Pin-enable bits: four commons, twelve segments
// - Pin driven only with global LCD on
// - Trim field selects regulator output voltage
// - Shutdown opens output; bypass shorts to core
// - Bits six, seven connect calibration capacitors
// - Switch code 00 opens, 11 closes output
// - Routing bits connect regulator to four pads
// - Select bit picks converter input pad, resets one
// - Select at one routes P3.3 to input
module acrb_top
  import acrb_pkg::*;
#(
  parameter logic [19:0] REFRESH_SLOW_CYC = 20'(ACRB_SLOW_CYC),
  parameter logic [19:0] REFRESH_MID_CYC  = 20'(ACRB_MID_CYC),
  parameter logic [19:0] REFRESH_FAST_CYC = 20'(ACRB_FAST_CYC)
)
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   power_on_reset_n,
  input  wire logic                   brownout_reset_n,
  input  wire logic                   s_axi_awvalid,
  output      logic                   s_axi_awready,
  input  wire logic [ACRB_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_wvalid,
  output      logic                   s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  output      logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output      logic [1:0]             s_axi_bresp,
  input  wire logic                   s_axi_arvalid,
  output      logic                   s_axi_arready,
  input  wire logic [ACRB_ADDR_W-1:0] s_axi_araddr,
  output      logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output      logic [31:0]            s_axi_rdata,
  output      logic [1:0]             s_axi_rresp,
  input  wire logic                   pump_output_ok,
  input  wire logic                   pump_ext_clock,
  input  wire logic                   lcd_global_on,
  output      acrb_pump_s             pump_out,
  output      acrb_lcd_s              lcd_out,
  output      acrb_ldo_s              ldo_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the whole block
  typedef struct packed {
    acrb_word_t [ACRB_NREG-1:0] regs;
    logic                       ok;
    logic                       aw_held;
    logic [ACRB_ADDR_W-1:0]     aw_addr;
    logic                       w_held;
    logic [15:0]                w_data;
    logic [1:0]                 w_strb;
    logic                       awready;
    logic                       wready;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [15:0]                rdata;
    logic [1:0]                 rresp;
    logic [3:0]                 half_cnt;
    logic [7:0]                 phase;
    logic [19:0]                ref_cnt;
    logic [11:0]                pulse_cnt;
    acrb_pump_s                 pump;
    acrb_lcd_s                  lcd;
    acrb_ldo_s                  ldo;
  } acrb_state_s;

  acrb_state_s s_reg;
  acrb_state_s s_next;
  logic        any_rst;

  assign any_rst = !aresetn || !power_on_reset_n || !brownout_reset_n;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode: valid flag and slot
  function automatic logic [3:0] acrb_decode(
    input logic [ACRB_ADDR_W-1:0] addr
  );
    logic [4:0] slot;
    slot = addr[ACRB_ADDR_W-1:3];
    if (addr[2:0] == 3'h0 && slot < 5'(ACRB_NREG))
    begin
      return {1'b1, slot[2:0]};
    end
    return 4'h0;
  endfunction : acrb_decode

  // Refresh period in cycles for a rate code
  function automatic logic [19:0] acrb_period(input logic [1:0] rate);
    case (rate)
      2'h0:    return REFRESH_SLOW_CYC;
      2'h3:    return REFRESH_FAST_CYC;
      default: return REFRESH_MID_CYC;
    endcase
  endfunction : acrb_period

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    logic [3:0]  dec;
    acrb_word_t  be;
    acrb_word_t  cm;
    acrb_word_t  pcfg;
    acrb_word_t  pctl;
    acrb_word_t  rcfg;
    acrb_word_t  rrte;
    logic        run;
    logic        src_clk;
    dec     = 4'h0;
    be      = 16'h0000;
    cm      = 16'h0000;
    pcfg    = 16'h0000;
    pctl    = s_reg.regs[ACRB_S_PCTL];
    rcfg    = 16'h0000;
    rrte    = 16'h0000;
    run     = 1'b0;
    src_clk = 1'b0;
    s_next  = s_reg;
    // Write response and read data handshakes complete
    if (s_reg.bvalid && s_axi_bready)
      s_next.bvalid = 1'b0;
    if (s_reg.rvalid && s_axi_rready)
      s_next.rvalid = 1'b0;
    // Address and data are captured independently
    if (s_axi_awvalid && s_reg.awready)
    begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready)
    begin
      s_next.w_held = 1'b1;
      s_next.w_data = s_axi_wdata[15:0];
      s_next.w_strb = s_axi_wstrb[1:0];
    end
    // Masked write, one cycle after both halves are held
    if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid)
    begin
      dec = acrb_decode(s_reg.aw_addr);
      be  = {{8{s_reg.w_strb[1]}}, {8{s_reg.w_strb[0]}}};
      if (dec[3])
      begin
        cm = be & ACRB_WMASK[dec[2:0]];
        s_next.regs[dec[2:0]] = (s_reg.regs[dec[2:0]] & ~cm) |
                                (s_reg.w_data & cm);
      end
      s_next.bresp   = dec[3] ? ACRB_RESP_OKAY : ACRB_RESP_SLVERR;
      s_next.bvalid  = 1'b1;
      s_next.aw_held = 1'b0;
      s_next.w_held  = 1'b0;
    end
    // Read capture, status bit merged into the config word
    if (s_axi_arvalid && s_reg.arready)
    begin
      dec = acrb_decode(s_axi_araddr);
      s_next.rdata = 16'h0000;
      if (dec[3])
        s_next.rdata = s_reg.regs[dec[2:0]];
      if (dec[3] && dec[2:0] == 3'(ACRB_S_PCFG))
        s_next.rdata[ACRB_F_OK] = s_reg.ok;
      s_next.rresp  = dec[3] ? ACRB_RESP_OKAY : ACRB_RESP_SLVERR;
      s_next.rvalid = 1'b1;
    end
    s_next.awready = !s_next.aw_held && !s_next.bvalid;
    s_next.wready  = !s_next.w_held && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;
    s_next.ok      = pump_output_ok;
    // Half-period ticks of the 4 MHz pump source
    if (s_reg.half_cnt == 4'(ACRB_HALF_CYC - 1))
    begin
      s_next.half_cnt = 4'h0;
      s_next.phase    = s_reg.phase + 8'h01;
    end
    else
      s_next.half_cnt = s_reg.half_cnt + 4'h1;
    // Refresh period counter and pulse stretcher
    if (s_reg.ref_cnt >= acrb_period(pctl[ACRB_F_RATE +: 2]) - 20'h1)
    begin
      s_next.ref_cnt   = 20'h0;
      s_next.pulse_cnt = 12'(ACRB_PULSE_CYC);
    end
    else
    begin
      s_next.ref_cnt = s_reg.ref_cnt + 20'h1;
      if (s_reg.pulse_cnt != 12'h000)
        s_next.pulse_cnt = s_reg.pulse_cnt - 12'h001;
    end
    // Reset classes: any reset is a normal one; wider ones add bits
    if (any_rst)
    begin
      for (int i = 0; i < ACRB_NREG; i++)
      begin
        cm = ACRB_PUC_M[i];
        if (!power_on_reset_n || !brownout_reset_n)
          cm = cm | ACRB_POR_M[i];
        if (!brownout_reset_n)
          cm = cm | ACRB_BOR_M[i];
        s_next.regs[i] = (s_next.regs[i] & ~cm) | (ACRB_RST[i] & cm);
      end
      s_next.ok        = 1'b0;
      s_next.aw_held   = 1'b0;
      s_next.w_held    = 1'b0;
      s_next.awready   = 1'b0;
      s_next.wready    = 1'b0;
      s_next.bvalid    = 1'b0;
      s_next.bresp     = ACRB_RESP_OKAY;
      s_next.arready   = 1'b0;
      s_next.rvalid    = 1'b0;
      s_next.rdata     = 16'h0000;
      s_next.rresp     = ACRB_RESP_OKAY;
      s_next.half_cnt  = 4'h0;
      s_next.phase     = 8'h00;
      s_next.ref_cnt   = 20'h0;
      s_next.pulse_cnt = 12'h000;
    end
    // Analog outputs from the next register contents
    pcfg = s_next.regs[ACRB_S_PCFG];
    pctl = s_next.regs[ACRB_S_PCTL];
    rcfg = s_next.regs[ACRB_S_RCFG];
    rrte = s_next.regs[ACRB_S_RRTE];
    src_clk = pcfg[ACRB_F_SRC] ? pump_ext_clock
              : s_next.phase[pcfg[ACRB_F_DIV +: 3]];
    run = pcfg[ACRB_F_TEST] ? pcfg[ACRB_F_FORCE]
                            : !s_next.ok;
    run = run && !pcfg[ACRB_F_PD] && !pctl[ACRB_F_QUIET];
    s_next.pump.power_down  = pcfg[ACRB_F_PD];
    s_next.pump.clock       = run && src_clk && !any_rst;
    s_next.pump.clamp       = pctl[ACRB_F_CLSRC] ? pcfg[ACRB_F_PD]
      : pctl[ACRB_F_FCLAMP];
    s_next.pump.threshold   = pcfg[ACRB_F_THR +: 3];
    s_next.pump.hysteresis  = pcfg[ACRB_F_HYST +: 2];
    s_next.pump.ext_cap     = pctl[ACRB_F_EXTCAP];
    s_next.pump.valid_level = pctl[ACRB_F_VLVL +: 2];
    s_next.pump.refresh_pulse = s_next.pulse_cnt != 12'h000;
    s_next.lcd.common  = s_next.regs[ACRB_S_LPIN][ACRB_F_COM +: 4] &
                         {4{lcd_global_on}};
    s_next.lcd.segment = s_next.regs[ACRB_S_LPIN][ACRB_F_SEG +: 12] &
                         {12{lcd_global_on}};
    s_next.ldo.trim          = rcfg[ACRB_F_TRIM +: 3];
    s_next.ldo.open          = rcfg[ACRB_F_SHUT];
    s_next.ldo.short_vdd     = rcfg[ACRB_F_BYP] && !rcfg[ACRB_F_SHUT];
    s_next.ldo.small_cap     = rcfg[ACRB_F_SCAP];
    s_next.ldo.large_cap     = rcfg[ACRB_F_LCAP];
    s_next.ldo.switch_closed =
      rcfg[ACRB_F_SW +: 2] == ACRB_SW_CLOSED;
    s_next.ldo.pad_route     = rrte[ACRB_F_PAD +: 4];
    s_next.ldo.a0_from_p3_3  = rrte[ACRB_F_ADC];
  end

  // State register
  always_ff @(posedge aclk)
  begin
    s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output ports straight from the state register
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready  = s_reg.wready;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = {16'h0000, s_reg.rdata};
  assign s_axi_rresp   = s_reg.rresp;
  assign pump_out      = s_reg.pump;
  assign lcd_out       = s_reg.lcd;
  assign ldo_out       = s_reg.ldo;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (any_rst);

  logic [11:0] hi_cnt;
  always_ff @(posedge aclk)
    hi_cnt <= s_reg.pump.refresh_pulse ? hi_cnt + 12'h001 : 12'h000;

  sequence s_both_held;
    s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
  endsequence

  sequence s_resp_out;
    s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endsequence

  property p_write_resp;
    s_both_held |=> s_resp_out;
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("write response not one cycle after capture");
  property p_lcd_gate;
    ##1 lcd_out.segment == (s_reg.regs[ACRB_S_LPIN][15:4] &
                            {12{$past(lcd_global_on)}});
  endproperty
  a_lcd_gate: assert property (p_lcd_gate)
    else $error("segment drive does not follow enable and global on");
  property p_clamp;
    pump_out.clamp == (s_reg.regs[ACRB_S_PCTL][ACRB_F_CLSRC]
      ? pump_out.power_down : s_reg.regs[ACRB_S_PCTL][ACRB_F_FCLAMP]);
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("clamp does not follow its selected source");
  property p_quiet;
    s_reg.regs[ACRB_S_PCTL][ACRB_F_QUIET] |-> !pump_out.clock;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("pump clocked while quiet");
  property p_power_down;
    $rose(s_reg.regs[ACRB_S_PCFG][ACRB_F_PD]) |->
      pump_out.power_down && !pump_out.clock ##1 !pump_out.clock;
  endproperty
  a_power_down: assert property (p_power_down)
    else $error("pump not stopped on power down");
  property p_test_hold;
    (s_reg.regs[ACRB_S_PCFG][ACRB_F_TEST] &&
     !s_reg.regs[ACRB_S_PCFG][ACRB_F_FORCE])[*2] |-> !pump_out.clock;
  endproperty
  a_test_hold: assert property (p_test_hold)
    else $error("pump clocked in test mode without force");
  property p_status;
    ##1 s_reg.ok == $past(pump_output_ok);
  endproperty
  a_status: assert property (p_status)
    else $error("valid flag does not track the pump comparator");
  property p_pulse_width;
    $fell(pump_out.refresh_pulse) |-> $past(hi_cnt) ==
      12'(ACRB_PULSE_CYC - 1);
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("refresh pulse width wrong");
  property p_regulator;
    ldo_out.short_vdd |-> !ldo_out.open && ldo_out.switch_closed ==
      (s_reg.regs[ACRB_S_RCFG][13:12] == ACRB_SW_CLOSED);
  endproperty
  a_regulator: assert property (p_regulator)
    else $error("regulator output controls inconsistent");

endmodule : acrb_top

// ===== tb/acrb_top_tb.sv
// Self-checking bench for the analog control register bank.
// Assumes the bank's AXI4-Lite timing and shortened refresh periods.
`timescale 1ns/100ps
module acrb_top_tb;
  import acrb_pkg::*;
  localparam logic [19:0] SLOW = 20'h00FA0;
  localparam logic [19:0] MID  = 20'h00BB8;
  localparam logic [19:0] FAST = 20'h009C4;
  logic             aclk = 1'b0;
  logic [2:0]       rn = 3'b000;
  logic             awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic             rready = 0, ok_in = 0, ext_clk = 0, lcd_on = 0, pdv = 1;
  logic             awready, wready, bvalid, arready, rvalid;
  logic [7:0]       awaddr = 0, araddr = 0;
  logic [31:0]      wdata = 0, rdata;
  logic [1:0]       bresp, rresp;
  logic [3:0]       strb = 4'hF;
  acrb_pump_s       pump_out;
  acrb_lcd_s        lcd_out;
  acrb_ldo_s        ldo_out;
  int               error_cnt = 0, n_tests = 0;

  acrb_top #(.REFRESH_SLOW_CYC(SLOW), .REFRESH_MID_CYC(MID),
    .REFRESH_FAST_CYC(FAST)) i_acrb_top (.aclk(aclk), .aresetn(rn[0]),
    .power_on_reset_n(rn[1]), .brownout_reset_n(rn[2]),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .pump_output_ok(ok_in), .pump_ext_clock(ext_clk),
    .lcd_global_on(lcd_on), .pump_out(pump_out), .lcd_out(lcd_out),
    .ldo_out(ldo_out));

  // Clock and random external pump clock
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) ext_clk <= 1'($urandom);

  ////////////////////////////////////////////////////////////////////////////
  // Compare, report and bus tasks
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic axw(input logic [7:0] a, input logic [15:0] d,
                     output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] q,
                     output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    q = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr

  // Cycles between two rises of pump clock or refresh pulse, high time
  task automatic gap(input bit sel, input int lim, output int per, hi);
    logic p, c;
    int   n;
    p = 1'b1;
    n = -1;
    per = 0;
    hi = 0;
    for (int k = 0; k < lim && n < 1; k++)
    begin
      @(negedge aclk);
      c = sel ? pump_out.clock : pump_out.refresh_pulse;
      if (c && !p) n++;
      if (n == 0) per++;
      if (n == 0 && c) hi++;
      p = c;
    end
  endtask : gap

  // Analog outputs expected from the word just written
  task automatic chk_out(input int s, input logic [15:0] d);
    logic [15:0] sn, ex;
    sn = '0;
    ex = '0;
    case (s)
      ACRB_S_PCFG:
      begin
        sn = 16'({pump_out.power_down, pump_out.threshold,
                  pump_out.hysteresis});
        ex = 16'({d[8], d[5:3], d[7:6]});
        pdv = d[8];
      end
      ACRB_S_PCTL:
      begin
        sn = 16'({pump_out.clamp, pump_out.ext_cap, pump_out.valid_level});
        ex = 16'({d[1] ? pdv : d[2], d[3], d[7:6]});
      end
      ACRB_S_LPIN:
      begin
        sn = lcd_out;
        ex = {d[3:0], d[15:4]} & {16{lcd_on}};
      end
      ACRB_S_RCFG:
      begin
        sn = 16'({ldo_out.trim, ldo_out.open, ldo_out.short_vdd,
                  ldo_out.small_cap, ldo_out.large_cap,
                  ldo_out.switch_closed});
        ex = 16'({d[2:0], d[4], d[5] & ~d[4], d[6], d[7],
                  d[13:12] == ACRB_SW_CLOSED});
      end
      ACRB_S_RRTE:
      begin
        sn = 16'({ldo_out.pad_route, ldo_out.a0_from_p3_3});
        ex = 16'({d[3:0], d[4]});
      end
      default: ;
    endcase
    chk("analog outputs", 32'(sn), 32'(ex));
  endtask : chk_out

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hung handshake
  initial
  begin
    repeat (80000) @(posedge aclk);
    error_cnt++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    logic [31:0] q;
    logic [1:0]  r;
    logic [15:0] d;
    int          per, hi;
    void'($urandom(32'h82C9));
    repeat (5) @(posedge aclk);
    rn <= 3'b111;
    for (int s = 0; s < ACRB_NREG; s++)
    begin
      axr(8'(8 * s), q, r);
      chk("reset value", q, 32'(ACRB_RST[s]));
    end
    chk("a0 select", 32'(ldo_out.a0_from_p3_3), 32'h1);
    chk("pump off", 32'(pump_out.power_down), 32'h1);
    // Corner and random words into every register
    for (int rd = 0; rd < 5; rd++)
      for (int s = 0; s < ACRB_NREG; s++)
      begin
        d = rd == 0 ? 16'hFFFF : rd == 1 ? 16'h0000 : 16'($urandom);
        lcd_on <= 1'($urandom);
        axw(8'(8 * s), d, r);
        chk("write resp", 32'(r), 32'(ACRB_RESP_OKAY));
        axr(8'(8 * s), q, r);
        chk("readback", q, 32'((ACRB_RST[s] & ~ACRB_WMASK[s]) |
            (d & ACRB_WMASK[s])));
        chk_out(s, d);
      end
    // Unmapped and unaligned places
    axw(8'h38, 16'hFFFF, r);
    chk("unmapped write", 32'(r), 32'(ACRB_RESP_SLVERR));
    axr(8'h04, q, r);
    chk("unaligned read", {q[29:0], r}, 32'(ACRB_RESP_SLVERR));
    // Each reset line restores the configuration word
    for (int i = 0; i < 3; i++)
    begin
      axw(8'h00, 16'h0000, r);
      rn[i] <= 1'b0;
      repeat (2) @(posedge aclk);
      rn[i] <= 1'b1;
      axr(8'h00, q, r);
      chk("class reset", q, 32'(ACRB_RST[0]));
    end
    // Pump clock period for divide codes 0 to 3, then quiet and test mode
    axw(8'h08, 16'h0000, r);
    for (int dv = 0; dv < 4; dv++)
    begin
      axw(8'h00, 16'(dv), r);
      gap(1'b1, 400, per, hi);
      gap(1'b1, 400, per, hi);
      chk("pump period", 32'(per), 32'(10 << dv));
    end
    axw(8'h08, 16'h0001, r);
    gap(1'b1, 200, per, hi);
    chk("quiet clock", 32'(per), 32'h0);
    axw(8'h08, 16'h0000, r);
    axw(8'h00, 16'h0200, r);
    gap(1'b1, 200, per, hi);
    chk("test mode stop", 32'(per), 32'h0);
    // Forced test clock, comparator stop and flag, byte lanes
    axw(8'h00, 16'h0600, r);
    gap(1'b1, 200, per, hi);
    chk("test mode force", 32'(per), 32'hA);
    ok_in <= 1'b1;
    axw(8'h00, 16'h0000, r);
    gap(1'b1, 200, per, hi);
    chk("comparator stop", 32'(per), 32'h0);
    axr(8'h00, q, r);
    chk("valid flag", q, 32'h1000);
    ok_in <= 1'b0;
    axw(8'h30, 16'h0000, r);
    strb <= 4'h1;
    axw(8'h30, 16'hABCD, r);
    strb <= 4'hF;
    axr(8'h30, q, r);
    chk("byte lane", q, 32'h00CD);
    // External clock source passes through one register stage
    axw(8'h00, 16'h0800, r);
    @(negedge aclk) q[0] = ext_clk;
    repeat (8)
    begin
      @(negedge aclk);
      chk("external clock", 32'(pump_out.clock), 32'(q[0]));
      q[0] = ext_clk;
    end
    // Refresh period and pulse width per rate code
    for (int c = 0; c < 4; c++)
    begin
      axw(8'h08, 16'(c << 4), r);
      gap(1'b0, 9000, per, hi);
      gap(1'b0, 9000, per, hi);
      chk("refresh period", 32'(per),
          32'(c == 0 ? SLOW : c == 3 ? FAST : MID));
      chk("refresh pulse", 32'(hi), 32'(ACRB_PULSE_CYC));
    end
    report_and_stop();
  end
endmodule : acrb_top_tb
